// ### rtl/rcr_map.svh
// Offsets, field positions, reset values and timing counts of the reset cause recorder
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// Register offsets
`define RCR_OFS_FLAGS     12'h000
`define RCR_OFS_ISTS      12'h004
`define RCR_OFS_IMASK     12'h008
`define RCR_OFS_PROT_LO   12'h00C
`define RCR_OFS_PROT_HI   12'h010
`define RCR_OFS_PROT_ENT  12'h014

// Flag bit positions
`define RCR_B_TRAP        15
`define RCR_B_ILLEGAL     14
`define RCR_B_MISMATCH    9
`define RCR_B_EXTPIN      7
`define RCR_B_SOFT        6
`define RCR_B_WDOG        4
`define RCR_B_SLEEP       3
`define RCR_B_IDLE        2
`define RCR_B_BROWNOUT    1
`define RCR_B_POWERON     0

// Field masks and reset values
`define RCR_FLAGS_MASK    16'hC2DF
`define RCR_FLAGS_RST     16'h0003
`define RCR_BO_CLR        16'hC25C
`define RCR_PROT_LO_RST   24'hFFFFFF
`define RCR_PROT_HI_RST   24'h000000
`define RCR_PROT_ENT_RST  24'h000000
`define RCR_SP_INIT       16'h8000

// Decode constants
`define RCR_ILLEGAL_OP    8'h3F
`define RCR_HARD_LO       4'hD
`define RCR_HARD_HI       4'hF
`define RCR_NPPS          4

// Timing
`define RCR_CLK_NS        25
`define RCR_RST_PULSE_NS  100
`define RCR_RST_CYC       ((`RCR_RST_PULSE_NS + `RCR_CLK_NS - 1) / `RCR_CLK_NS)

`endif

// ### rtl/rcr_pkg.sv
// Types of the reset cause recorder
package rcr_pkg;

    typedef enum logic {ST_RUN, ST_RST} rcr_state_t;

    typedef struct packed {
        logic [15:0] shadow;
        logic        mis;
    } rcr_shd_st_t;

    typedef struct packed {
        logic [15:0] init;
        logic        hit;
    } rcr_wreg_st_t;

    typedef struct packed {
        rcr_state_t  st;
        logic [2:0]  cnt;
        logic [15:0] flags;
        logic [15:0] ists;
        logic [15:0] imask;
        logic [23:0] plo;
        logic [23:0] phi;
        logic [23:0] pent;
        logic [31:0] prdata;
        logic        slverr;
    } rcr_main_st_t;

endpackage : rcr_pkg

// ### rtl/rcr_shadow_cmp.sv
// Shadow copy of one pin-select register with continuous compare
`timescale 1ns/10ps
`include "rcr_map.svh"
module rcr_shadow_cmp (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Live register and legitimate updates
    input  wire logic [15:0] live,
    input  wire logic        load,
    input  wire logic [15:0] load_data,
    input  wire logic        clr,
    // Result
    output logic             mismatch
);
    rcr_pkg::rcr_shd_st_t s_r;
    rcr_pkg::rcr_shd_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (clr) begin
            s_nxt.shadow = 16'h0000;
        end else if (load) begin
            s_nxt.shadow = load_data;
        end
        // Compare suppressed while the pair is being rewritten
        s_nxt.mis = !clr && !load && (live != s_r.shadow);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mismatch = s_r.mis;
endmodule : rcr_shadow_cmp

// ### rtl/rcr_wreg_track.sv
// Tracks which working registers have been written since the last reset
`timescale 1ns/10ps
`include "rcr_map.svh"
module rcr_wreg_track (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register writes and pointer uses
    input  wire logic       wr,
    input  wire logic [3:0] wr_idx,
    input  wire logic       ptr_valid,
    input  wire logic [3:0] ptr_idx,
    input  wire logic       clr,
    // Result
    output logic            uninit_hit
);
    rcr_pkg::rcr_wreg_st_t s_r;
    rcr_pkg::rcr_wreg_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.hit = ptr_valid && !s_r.init[ptr_idx];
        if (wr) begin
            s_nxt.init[wr_idx] = 1'b1;
        end
        if (clr) begin
            s_nxt.init = `RCR_SP_INIT;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= rcr_pkg::rcr_wreg_st_t'{init: `RCR_SP_INIT, hit: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign uninit_hit = s_r.hit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    wreg_clear_a: assert property (clr |=> s_r.init == `RCR_SP_INIT)
        else $error("working registers not cleared on reset");
endmodule : rcr_wreg_track

// ### rtl/rcr_top.sv
// Reset source detection and reset cause flag register with APB access
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "rcr_map.svh"
module rcr_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Instruction execution
    input  wire logic        exec_valid,
    input  wire logic [23:0] exec_word,
    input  wire logic        exec_invalid,
    // Working register use
    input  wire logic        wreg_wr,
    input  wire logic [3:0]  wreg_wr_idx,
    input  wire logic        ptr_valid,
    input  wire logic [3:0]  ptr_idx,
    // Program counter reloads
    input  wire logic        program_flow_change,
    input  wire logic        vector_flow_change,
    input  wire logic [23:0] pc_target,
    // Hard traps
    input  wire logic        trap_evt,
    input  wire logic [3:0]  trap_prio,
    input  wire logic        trap_busy,
    input  wire logic [3:0]  trap_busy_prio,
    // Other reset sources and instructions
    input  wire logic        brownout_evt,
    input  wire logic        external_reset_pin,
    input  wire logic        soft_reset_instruction,
    input  wire logic        watchdog_timeout,
    input  wire logic        power_save_instruction,
    input  wire logic        power_save_idle,
    input  wire logic        watchdog_clear_instruction,
    // Pin-select registers
    input  wire logic [63:0] pps_live,
    input  wire logic        pps_wr,
    input  wire logic [1:0]  pps_wr_idx,
    input  wire logic [15:0] pps_wr_data,
    // Reset request
    output logic             rst_req
);
    rcr_pkg::rcr_main_st_t s_r;
    rcr_pkg::rcr_main_st_t s_nxt;

    logic [`RCR_NPPS-1:0] mis_vec;
    logic                 mismatch_any;
    logic                 uninit_hit;
    logic                 ill_op;
    logic                 sec_hit;
    logic                 conflict;
    logic                 cause;
    logic [15:0]          hw_set;
    logic [15:0]          hw_clr;
    logic                 apb_setup;
    logic                 apb_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin-select shadows
    genvar gi;
    generate
        for (gi = 0; gi < `RCR_NPPS; gi++) begin : g_shd
            rcr_shadow_cmp u_shd (
                .clk       (clk),
                .rstn      (rstn),
                .live      (pps_live[gi*16 +: 16]),
                .load      (pps_wr && (pps_wr_idx == 2'(gi))),
                .load_data (pps_wr_data),
                .clr       (rst_req),
                .mismatch  (mis_vec[gi])
            );
        end
    endgenerate

    assign mismatch_any = |mis_vec;

    ////////////////////////////////////////////////////////////////////////////
    // Working register tracking
    rcr_wreg_track u_wreg (
        .clk        (clk),
        .rstn       (rstn),
        .wr         (wreg_wr),
        .wr_idx     (wreg_wr_idx),
        .ptr_valid  (ptr_valid),
        .ptr_idx    (ptr_idx),
        .clr        (rst_req || brownout_evt || external_reset_pin ||
                     soft_reset_instruction || watchdog_timeout),
        .uninit_hit (uninit_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reset cause detection
    always_comb begin
        ill_op = exec_valid &&
                 (exec_invalid || exec_word[23:16] == `RCR_ILLEGAL_OP);
        // Protection is off while the upper bound is below the lower one
        sec_hit = (program_flow_change || vector_flow_change) &&
                  (s_r.phi >= s_r.plo) &&
                  (pc_target >= s_r.plo) && (pc_target <= s_r.phi) &&
                  (pc_target != s_r.pent);
        conflict = trap_evt && trap_busy &&
                   (trap_prio >= `RCR_HARD_LO) && (trap_prio <= `RCR_HARD_HI) &&
                   (trap_busy_prio > trap_prio);
        cause = conflict || ill_op || sec_hit || uninit_hit || mismatch_any;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag set and clear events
    always_comb begin
        hw_set = 16'h0000;
        hw_set[`RCR_B_TRAP]     = conflict;
        hw_set[`RCR_B_ILLEGAL]  = ill_op || uninit_hit || sec_hit;
        hw_set[`RCR_B_MISMATCH] = mismatch_any;
        hw_set[`RCR_B_EXTPIN]   = external_reset_pin;
        hw_set[`RCR_B_SOFT]     = soft_reset_instruction;
        hw_set[`RCR_B_WDOG]     = watchdog_timeout;
        hw_set[`RCR_B_SLEEP]    = power_save_instruction && !power_save_idle;
        hw_set[`RCR_B_IDLE]     = power_save_instruction && power_save_idle;
        hw_set[`RCR_B_BROWNOUT] = brownout_evt;
        hw_clr = brownout_evt ? `RCR_BO_CLR : 16'h0000;
        if (power_save_instruction || watchdog_clear_instruction) begin
            hw_clr[`RCR_B_WDOG] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB phases
    assign apb_setup = psel && !penable;
    assign pready    = psel && penable;
    assign apb_wr    = pready && pwrite && !s_r.slverr;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_nxt = s_r;

        // Reset request pulse
        case (s_r.st)
            rcr_pkg::ST_RUN: begin
                if (cause) begin
                    s_nxt.st  = rcr_pkg::ST_RST;
                    s_nxt.cnt = 3'(`RCR_RST_CYC - 1);
                end
            end
            rcr_pkg::ST_RST: begin
                if (s_r.cnt == 3'h0) begin
                    s_nxt.st = rcr_pkg::ST_RUN;
                end else begin
                    s_nxt.cnt = s_r.cnt - 3'h1;
                end
            end
            default: begin
                s_nxt.st = rcr_pkg::ST_RUN;
            end
        endcase

        // Flags: software write, then hardware clear, then hardware set
        if (apb_wr && paddr == `RCR_OFS_FLAGS) begin
            s_nxt.flags = pwdata[15:0];
        end
        s_nxt.flags = (s_nxt.flags & ~hw_clr) | hw_set;
        s_nxt.flags = s_nxt.flags & `RCR_FLAGS_MASK;

        // Interrupt status, write one to clear, new events win
        if (apb_wr && paddr == `RCR_OFS_ISTS) begin
            s_nxt.ists = s_r.ists & ~pwdata[15:0];
        end
        s_nxt.ists = (s_nxt.ists | hw_set) & `RCR_FLAGS_MASK;

        if (apb_wr) begin
            case (paddr)
                `RCR_OFS_IMASK:    s_nxt.imask = pwdata[15:0] & `RCR_FLAGS_MASK;
                `RCR_OFS_PROT_LO:  s_nxt.plo   = pwdata[23:0];
                `RCR_OFS_PROT_HI:  s_nxt.phi   = pwdata[23:0];
                `RCR_OFS_PROT_ENT: s_nxt.pent  = pwdata[23:0];
                default: begin
                end
            endcase
        end

        // Read data and decode captured in the setup cycle
        if (apb_setup) begin
            s_nxt.slverr = 1'b0;
            case (paddr)
                `RCR_OFS_FLAGS:    s_nxt.prdata = {16'h0000, s_r.flags};
                `RCR_OFS_ISTS:     s_nxt.prdata = {16'h0000, s_r.ists};
                `RCR_OFS_IMASK:    s_nxt.prdata = {16'h0000, s_r.imask};
                `RCR_OFS_PROT_LO:  s_nxt.prdata = {8'h00, s_r.plo};
                `RCR_OFS_PROT_HI:  s_nxt.prdata = {8'h00, s_r.phi};
                `RCR_OFS_PROT_ENT: s_nxt.prdata = {8'h00, s_r.pent};
                default: begin
                    s_nxt.prdata = 32'h00000000;
                    s_nxt.slverr = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; block reset stands for power-on
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= rcr_pkg::rcr_main_st_t'{
                st:     rcr_pkg::ST_RUN,
                cnt:    3'h0,
                flags:  `RCR_FLAGS_RST,
                ists:   16'h0000,
                imask:  16'h0000,
                plo:    `RCR_PROT_LO_RST,
                phi:    `RCR_PROT_HI_RST,
                pent:   `RCR_PROT_ENT_RST,
                prdata: 32'h00000000,
                slverr: 1'b0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata  = s_r.prdata;
    assign pslverr = s_r.slverr;
    assign irq     = |(s_r.ists & s_r.imask);
    assign rst_req = (s_r.st == rcr_pkg::ST_RST);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    mismatch_flag_a: assert property (mismatch_any |=> s_r.flags[`RCR_B_MISMATCH])
        else $error("mismatch did not set its flag");

    illegal_op_a: assert property (
        exec_valid && exec_word[23:16] == `RCR_ILLEGAL_OP |=> s_r.flags[`RCR_B_ILLEGAL])
        else $error("illegal opcode did not set its flag");

    invalid_rst_a: assert property (
        exec_valid && exec_invalid && s_r.st == rcr_pkg::ST_RUN |=> rst_req)
        else $error("invalid instruction did not request reset");

    uninit_flag_a: assert property (uninit_hit |=> s_r.flags[`RCR_B_ILLEGAL] && rst_req)
        else $error("uninitialized pointer use missed");

    security_rst_a: assert property (sec_hit |=> s_r.flags[`RCR_B_ILLEGAL])
        else $error("security violation did not set its flag");

    trap_conflict_a: assert property (conflict |=> s_r.flags[`RCR_B_TRAP])
        else $error("trap conflict did not set its flag");

    hard_range_a: assert property (
        trap_evt && trap_busy && trap_prio < `RCR_HARD_LO && !cause
        && s_r.st == rcr_pkg::ST_RUN |=> !rst_req)
        else $error("soft trap treated as conflict");

    extpin_keep_a: assert property (
        brownout_evt && !external_reset_pin && !apb_wr
        |=> s_r.flags[`RCR_B_EXTPIN] == $past(s_r.flags[`RCR_B_EXTPIN]))
        else $error("brown-out disturbed external pin flag");

    soft_flag_a: assert property (soft_reset_instruction |=> s_r.flags[`RCR_B_SOFT])
        else $error("reset instruction did not set its flag");

    wdog_clear_a: assert property (
        watchdog_clear_instruction && !watchdog_timeout |=> !s_r.flags[`RCR_B_WDOG])
        else $error("watchdog flag not cleared");

    brownout_set_a: assert property (
        brownout_evt |=> s_r.flags[`RCR_B_BROWNOUT] && !s_r.flags[`RCR_B_SOFT])
        else $error("brown-out flag handling wrong");

    rst_pulse_a: assert property ($rose(rst_req) |-> rst_req[*4] ##1 !rst_req)
        else $error("reset request pulse length wrong");

    reserved_a: assert property ((s_r.flags & ~`RCR_FLAGS_MASK) == 16'h0000)
        else $error("reserved flag bit set");

    sleep_flag_a: assert property (power_save_instruction && !power_save_idle |=> s_r.flags[`RCR_B_SLEEP])
        else $error("sleep flag not set");

    idle_flag_a: assert property (power_save_instruction && power_save_idle |=> s_r.flags[`RCR_B_IDLE])
        else $error("idle flag not set");

    wdog_set_a: assert property (watchdog_timeout |=> s_r.flags[`RCR_B_WDOG])
        else $error("watchdog time-out did not set its flag");

    ps_wdog_a: assert property (power_save_instruction && !watchdog_timeout |=> !s_r.flags[`RCR_B_WDOG])
        else $error("power-save did not clear watchdog flag");

    extpin_set_a: assert property (external_reset_pin |=> s_r.flags[`RCR_B_EXTPIN])
        else $error("external pin reset did not set its flag");

    poweron_keep_a: assert property (
        !(apb_wr && paddr == `RCR_OFS_FLAGS) |=> $stable(s_r.flags[`RCR_B_POWERON]))
        else $error("power-on flag changed without software");

    brownout_clr_a: assert property (
        brownout_evt && hw_set == 16'h0002 && !apb_wr |=> (s_r.flags & `RCR_BO_CLR) == 16'h0000)
        else $error("brown-out left a flag set");

    ists_set_a: assert property (hw_set[`RCR_B_ILLEGAL] |=> s_r.ists[`RCR_B_ILLEGAL])
        else $error("illegal condition did not raise its status");

    flag_write_a: assert property (
        apb_wr && paddr == `RCR_OFS_FLAGS && hw_set == 16'h0000 && hw_clr == 16'h0000
        |=> {16'h0000, s_r.flags} == ($past(pwdata) & {16'h0000, `RCR_FLAGS_MASK}))
        else $error("software flag write lost");

    rst_hold_a: assert property (rst_req && s_r.cnt != 3'h0 |=> rst_req)
        else $error("reset request ended early");

    rst_end_a: assert property (rst_req && s_r.cnt == 3'h0 |=> !rst_req)
        else $error("reset request too long");

    no_cause_a: assert property (s_r.st == rcr_pkg::ST_RUN && !cause |=> !rst_req)
        else $error("reset request without a cause");

    branch_hit_a: assert property (
        program_flow_change && s_r.st == rcr_pkg::ST_RUN && s_r.phi >= s_r.plo &&
        pc_target >= s_r.plo && pc_target <= s_r.phi && pc_target != s_r.pent |=> rst_req)
        else $error("branch into protected range did not reset");

    vector_hit_a: assert property (
        vector_flow_change && s_r.st == rcr_pkg::ST_RUN && s_r.phi >= s_r.plo &&
        pc_target >= s_r.plo && pc_target <= s_r.phi && pc_target != s_r.pent |=> rst_req)
        else $error("vector into protected range did not reset");
endmodule : rcr_top

// ### test/tb_reset_cause_recorder.sv
// Self-checking testbench of the reset cause recorder
`timescale 1ns/10ps
`include "rcr_map.svh"
module tb_reset_cause_recorder;
    typedef struct packed {
        logic [15:0] pre;
        logic [4:0]  act;
        logic [23:0] tgt;
        logic [15:0] exp;
        logic [3:0]  nrst;
    } rcr_row_t;
    ////////////////////////////////////////////////////////////////////////////
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, irq, rst_req, e;
    logic        exec_valid = 1'b0, exec_invalid = 1'b0, wreg_wr = 1'b0, ptr_valid = 1'b0;
    logic [23:0] exec_word = 24'h0, pc_target = 24'h0;
    logic [3:0]  wreg_wr_idx = 4'h0, ptr_idx = 4'h0, trap_prio = 4'h0, trap_busy_prio = 4'h0;
    logic        program_flow_change = 1'b0, vector_flow_change = 1'b0, trap_evt = 1'b0, trap_busy = 1'b0;
    logic        brownout_evt = 1'b0, external_reset_pin = 1'b0, soft_reset_instruction = 1'b0;
    logic        watchdog_timeout = 1'b0, power_save_instruction = 1'b0, power_save_idle = 1'b0;
    logic        watchdog_clear_instruction = 1'b0, pps_wr = 1'b0;
    logic [63:0] pps_live = 64'h0;
    logic [1:0]  pps_wr_idx = 2'h0;
    logic [15:0] pps_wr_data = 16'h0;
    logic [31:0] n;
    int          errors = 0, checks = 0;
    rcr_row_t    rows[24];

    always #12.5 clk = ~clk;

    rcr_top DUT (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .exec_valid, .exec_word, .exec_invalid, .wreg_wr, .wreg_wr_idx, .ptr_valid, .ptr_idx,
        .program_flow_change, .vector_flow_change, .pc_target, .trap_evt, .trap_prio, .trap_busy,
        .trap_busy_prio, .brownout_evt, .external_reset_pin, .soft_reset_instruction, .watchdog_timeout,
        .power_save_instruction, .power_save_idle, .watchdog_clear_instruction, .pps_live, .pps_wr,
        .pps_wr_idx, .pps_wr_data, .rst_req);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One-cycle pulse of a cause or instruction input
    task automatic act(input logic [4:0] k, input logic [23:0] t);
        @(posedge clk);
        case (k)
            5'h00: begin exec_valid <= 1'b1; exec_word <= t; end
            5'h01: begin exec_valid <= 1'b1; exec_invalid <= 1'b1; end
            5'h02: begin trap_evt <= 1'b1; trap_prio <= 4'hC; trap_busy <= 1'b1; trap_busy_prio <= 4'hE; end
            5'h03: begin trap_evt <= 1'b1; trap_prio <= 4'hD; trap_busy <= 1'b1; trap_busy_prio <= 4'hE; end
            5'h04: external_reset_pin <= 1'b1;
            5'h05: soft_reset_instruction <= 1'b1;
            5'h06: watchdog_timeout <= 1'b1;
            5'h07: power_save_instruction <= 1'b1;
            5'h08: begin power_save_instruction <= 1'b1; power_save_idle <= 1'b1; end
            5'h09: brownout_evt <= 1'b1;
            5'h0A: watchdog_clear_instruction <= 1'b1;
            5'h0B: pps_live[15:0] <= 16'h0001;
            5'h0C: begin pps_wr <= 1'b1; pps_wr_idx <= 2'h1; pps_wr_data <= t[15:0]; pps_live[31:16] <= t[15:0]; end
            5'h0D: begin trap_evt <= 1'b1; trap_prio <= 4'hD; trap_busy <= 1'b1; trap_busy_prio <= 4'hC; end
            5'h0E: begin wreg_wr <= 1'b1; wreg_wr_idx <= 4'h5; end
            5'h0F: begin ptr_valid <= 1'b1; ptr_idx <= t[3:0]; end
            5'h10: begin program_flow_change <= 1'b1; pc_target <= t; end
            5'h11: begin vector_flow_change <= 1'b1; pc_target <= t; end
            default: ;
        endcase
        @(posedge clk);
        {exec_valid, exec_invalid, trap_evt, trap_busy, external_reset_pin, soft_reset_instruction} <= 6'h00;
        {watchdog_timeout, power_save_instruction, power_save_idle, brownout_evt} <= 4'h0;
        {watchdog_clear_instruction, pps_wr, wreg_wr, ptr_valid, program_flow_change, vector_flow_change} <= 6'h00;
        pps_live[15:0] <= 16'h0000;
    endtask : act

    // Counts reset request cycles over the next eight edges
    task automatic cnt(output logic [31:0] c);
        c = 0;
        repeat (8) begin
            #1;
            if (rst_req === 1'b1) c++;
            @(posedge clk);
        end
    endtask : cnt

    task complete_run;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 20000);
        errors++;
        complete_run();
    end

    initial begin
        rows = '{'{16'h0000, 5'h00, 24'h3F1234, 16'h4000, 4'h4},
                 '{16'h0000, 5'h00, 24'h3E1234, 16'h0000, 4'h0},
                 '{16'h0000, 5'h01, 24'h000000, 16'h4000, 4'h4},
                 '{16'h0000, 5'h0F, 24'h000003, 16'h4000, 4'h4},
                 '{16'h0000, 5'h0E, 24'h000000, 16'h0000, 4'h0},
                 '{16'h0000, 5'h0F, 24'h000005, 16'h0000, 4'h0},
                 '{16'h0000, 5'h03, 24'h000000, 16'h8000, 4'h4},
                 '{16'h0000, 5'h0D, 24'h000000, 16'h0000, 4'h0},
                 '{16'h0000, 5'h04, 24'h000000, 16'h0080, 4'hF},
                 '{16'h0000, 5'h05, 24'h000000, 16'h0040, 4'hF},
                 '{16'h0000, 5'h06, 24'h000000, 16'h0010, 4'hF},
                 '{16'h0000, 5'h07, 24'h000000, 16'h0008, 4'h0},
                 '{16'h0000, 5'h08, 24'h000000, 16'h0004, 4'h0},
                 '{16'hFFFF, 5'h09, 24'h000000, 16'h0083, 4'hF},
                 '{16'hFFFF, 5'h0A, 24'h000000, 16'hC2CF, 4'h0},
                 '{16'hFFFF, 5'h08, 24'h000000, 16'hC2CF, 4'h0},
                 '{16'h0000, 5'h0B, 24'h000000, 16'h0200, 4'h4},
                 '{16'h0000, 5'h0C, 24'h001234, 16'h0000, 4'h0},
                 '{16'h0000, 5'h0C, 24'h000000, 16'h0000, 4'h0},
                 '{16'h0000, 5'h10, 24'h000150, 16'h4000, 4'h4},
                 '{16'h0000, 5'h11, 24'h000100, 16'h0000, 4'h0},
                 '{16'h0000, 5'h11, 24'h0001FF, 16'h4000, 4'h4},
                 '{16'h0000, 5'h10, 24'h000200, 16'h0000, 4'h0},
                 '{16'h0000, 5'h02, 24'h000000, 16'h0000, 4'h0}};
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b1, `RCR_OFS_PROT_LO, 32'h0000_0100);
        apb(1'b1, `RCR_OFS_PROT_HI, 32'h0000_01FF);
        apb(1'b1, `RCR_OFS_PROT_ENT, 32'h0000_0100);
        for (int i = 0; i < 24; i++) begin
            apb(1'b1, `RCR_OFS_FLAGS, {16'h0000, rows[i].pre});
            act(rows[i].act, rows[i].tgt);
            cnt(n);
            if (rows[i].nrst != 4'hF) chk(n, {28'h0, rows[i].nrst});
            apb(1'b0, `RCR_OFS_FLAGS, 32'h0);
            chk(q, {16'h0000, rows[i].exp});
            $display("row %0d done", i);
        end
        // Second cause inside a running request does not stretch it
        apb(1'b1, `RCR_OFS_FLAGS, 32'h0);
        act(5'h01, 24'h0);
        act(5'h03, 24'h0);
        cnt(n);
        chk(n, 32'h2);
        apb(1'b0, `RCR_OFS_FLAGS, 32'h0);
        chk(q, 32'h0000_C000);
        $display("overlap done");
        // Interrupt raise, mask and clear
        apb(1'b1, `RCR_OFS_ISTS, 32'h0000_FFFF);
        apb(1'b1, `RCR_OFS_IMASK, 32'h0000_4000);
        act(5'h00, 24'h3F0000);
        cnt(n);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, `RCR_OFS_ISTS, 32'h0);
        chk(q, 32'h0000_4000);
        apb(1'b1, `RCR_OFS_IMASK, 32'h0);
        #1 chk({31'h0, irq}, 32'h0);
        apb(1'b1, `RCR_OFS_IMASK, 32'h0000_4000);
        #1 chk({31'h0, irq}, 32'h1);
        apb(1'b1, `RCR_OFS_ISTS, 32'h0000_4000);
        #1 chk({31'h0, irq}, 32'h0);
        $display("interrupt done");
        // Unmapped address and flag write access
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b1, `RCR_OFS_FLAGS, 32'hFFFF_FFFF);
        apb(1'b0, `RCR_OFS_FLAGS, 32'h0);
        chk(q, 32'h0000_C2DF);
        apb(1'b1, `RCR_OFS_FLAGS, 32'h0);
        apb(1'b0, `RCR_OFS_FLAGS, 32'h0);
        chk(q, 32'h0);
        $display("access done");
        // Reset in mid-run
        apb(1'b1, `RCR_OFS_IMASK, 32'h0000_FFFF);
        act(5'h05, 24'h0);
        #1 chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, `RCR_OFS_FLAGS, 32'h0);
        chk(q, 32'h0000_0003);
        apb(1'b0, `RCR_OFS_IMASK, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `RCR_OFS_PROT_LO, 32'h0);
        chk(q, 32'h00FF_FFFF);
        chk({31'h0, irq}, 32'h0);
        $display("reset done");
        complete_run();
    end
endmodule : tb_reset_cause_recorder
